// ===== rtdm_link_model.sv
`default_nettype none
module rtdm_link_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [31:0] arr,
    output logic [3:0] carrier
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] cnt = 8'h00;
    // one frame per go, so the ring is empty between measurements
    always @(posedge core_clk) begin
        cnt <= go ? cnt + 8'h01 : 8'h00;
        for (int p = 0; p < 4; p++) carrier[p] <= go && cnt >= arr[8*p+:8];
    end
endmodule
`default_nettype wire

// ===== rtdm_monitor.sv
`default_nettype none
module rtdm_monitor (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire rtdm_pkg::rtdm_acc_s acc,
    input wire rtdm_pkg::rtdm_rsp_s rsp,
    input wire logic [63:0] local_time,
    input wire logic [31:0] sys_time_diff,
    input wire logic sys_time_rx_valid,
    input wire logic sys_time_diff_valid
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic rd;
    // a byte read request; writes never answer
    assign rd = acc.valid && !acc.write;
    a_time_step: assert property (rst_n && $past(rst_n) |-> local_time == $past(local_time) + 64'h32)
        else $error("time step");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n |=> local_time == 64'h0)
        else $error("reset time");
    a_read_answer: assert property (rd |=> rsp.valid)
        else $error("no answer");
    a_no_answer: assert property (!rd |=> !rsp.valid)
        else $error("stray answer");
    a_latch_bits: assert property (rd && acc.addr == 16'h0936 |=> rsp.data[7:1] == 7'h00)
        else $error("latch bits");
    a_unmapped_zero: assert property (rd && acc.addr[15:3] == 13'h0122 |=> rsp.data == 8'h00)
        else $error("unmapped data");
    a_diff_answer: assert property (sys_time_rx_valid |=> sys_time_diff_valid)
        else $error("diff missing");
    a_diff_quiet: assert property (!sys_time_rx_valid |=> !sys_time_diff_valid)
        else $error("diff stray");
    a_diff_holds: assert property (!sys_time_rx_valid |=> $stable(sys_time_diff))
        else $error("diff moved");
endmodule
bind rtdm_top rtdm_monitor rtdm_monitor_i (.core_clk(core_clk), .rst_n(rst_n), .acc(acc),
    .rsp(rsp), .local_time(local_time), .sys_time_diff(sys_time_diff),
    .sys_time_rx_valid(sys_time_rx_valid), .sys_time_diff_valid(sys_time_diff_valid));
`default_nettype wire

// ===== rtdm_pin_sync.sv
`default_nettype none
module rtdm_pin_sync (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [rtdm_pkg::NPORTS-1:0] pin_in,
    output logic [rtdm_pkg::NPORTS-1:0] level,
    output logic [rtdm_pkg::NPORTS-1:0] rise
);
    typedef struct packed {
        logic [rtdm_pkg::NPORTS-1:0] s1;
        logic [rtdm_pkg::NPORTS-1:0] s2;
        logic [rtdm_pkg::NPORTS-1:0] s3;
        logic [rtdm_pkg::NPORTS-1:0] lvl;
        logic [rtdm_pkg::NPORTS-1:0] rise;
    } rtdm_sync_s;

    rtdm_sync_s st_r;
    rtdm_sync_s st_nxt;

    // a change counts only once stages two and three agree; stage one feeds stage two only
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int p = 0; p < rtdm_pkg::NPORTS; p++) begin
            if (st_r.s2[p] == st_r.s3[p]) begin
                st_nxt.lvl[p] = st_r.s3[p];
            end
        end
        st_nxt.rise = st_nxt.lvl & ~st_r.lvl;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level = st_r.lvl;
    assign rise = st_r.rise;
endmodule
`default_nettype wire

// ===== rtdm_pkg.sv
// How it works
// - local time at first preamble bit captured separately on ports 0 to 3.
// - capture uses raw local time only; no synchronisation needed beforehand.
// - devices with more than two ports must implement receive stamping.
// - arming variant latches next frame on ports other than 0, port 0 open.
// - 64-bit local time captured when frame reaches the processing unit.
// - capture works with master on port 0 or on ports 1 to 3; the arming variant ignores latch orientation, port 0 is always entry.
// - delay register is subtracted when comparing local and received time.
`default_nettype none
package rtdm_pkg;
    localparam int NPORTS = 4;
    localparam int SYNC_STAGES = 3;
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [63:0] LOCAL_TICK_NS = 64'(CLK_PERIOD_NS);
    // register byte addresses
    localparam logic [15:0] ADDR_STAMP0 = 16'h0900;
    localparam logic [15:0] ADDR_STAMP1 = 16'h0904;
    localparam logic [15:0] ADDR_STAMP2 = 16'h0908;
    localparam logic [15:0] ADDR_STAMP3 = 16'h090c;
    localparam logic [15:0] ADDR_PU_STAMP = 16'h0918;
    localparam logic [15:0] ADDR_DELAY = 16'h0928;
    localparam logic [15:0] ADDR_LATCH = 16'h0936;
    // latch orientation values and reset values
    localparam logic [7:0] LATCH_FORWARD = 8'h00;
    localparam logic [7:0] LATCH_REVERSE = 8'h01;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [31:0] DELAY_RESET = 32'h0000_0000;
    localparam logic [31:0] STAMP_RESET = 32'h0000_0000;
    localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } rtdm_acc_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rtdm_rsp_s;
endpackage
`default_nettype wire

// ===== rtdm_tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    rtdm_pkg::rtdm_acc_s acc = '0;
    rtdm_pkg::rtdm_rsp_s rsp;
    logic [3:0] carrier;
    logic pu = 1'b0;
    logic [31:0] st = 32'h0;
    logic st_v = 1'b0;
    logic [63:0] lt;
    logic [31:0] diff;
    logic diff_v;
    logic go = 1'b0;
    logic [31:0] arr = 32'h0;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    logic [63:0] s [4];
    logic [63:0] v;
    logic [63:0] t;
    // processing minus forwarding delay of the device type, a fixed figure; value arbitrary
    logic [63:0] proc_fwd_delay_difference = 64'h14;
    rtdm_top rtdm_top_i (.core_clk(core_clk), .rst_n(rst_n), .acc(acc), .rsp(rsp),
        .port_rx_pin(carrier), .port_open(4'h1), .pu_frame_start(pu), .sys_time_rx(st),
        .sys_time_rx_valid(st_v), .local_time(lt), .sys_time_diff(diff), .sys_time_diff_valid(diff_v));
    rtdm_link_model rtdm_link_model_i (.core_clk(core_clk), .go(go), .arr(arr), .carrier(carrier));
    // clock; cyc mirrors the local time count, and caps the run
    initial forever #25 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc <= rst_n ? cyc + 1 : 0;
        if (cyc > 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one byte access; a read answer is taken one edge after the request
    task automatic acc_byte(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        acc <= '{1'b1, w, a, d};
        @(posedge core_clk);
        acc.valid <= 1'b0;
        #1;
    endtask
    task automatic rdn(input logic [15:0] a, input int n, output logic [63:0] r);
        r = '0;
        for (int i = 0; i < n; i++) begin
            acc_byte(1'b0, a + 16'(i), 8'h00);
            r[8*i+:8] = rsp.data;
        end
    endtask
    task automatic wrn(input logic [15:0] a, input int n, input logic [63:0] d);
        for (int i = 0; i < n; i++) acc_byte(1'b1, a + 16'(i), d[8*i+:8]);
    endtask
    // arrival offsets per port in cycles; only differences are compared
    task automatic measure(input logic [31:0] a, input logic [7:0] mode, input int e);
        wrn(16'h0936, 1, {56'h0, mode});
        @(posedge core_clk);
        arr <= a;
        go <= 1'b1;
        repeat (12) @(posedge core_clk);
        wrn(16'h0900, 1, 64'h0);
        repeat (60) @(posedge core_clk);
        for (int p = 0; p < 4; p++) rdn(16'h0900 + 16'(4 * p), 4, s[p]);
        for (int p = 0; p < 4; p++) chk(s[p] - s[e], (64'(a[8*p+:8]) - 64'(a[8*e+:8])) * 64'h32);
        @(posedge core_clk);
        go <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        rdn(16'h0928, 4, v);
        chk(v, 64'h0);
        wrn(16'h0928, 4, 64'h1234_5678);
        rdn(16'h0928, 4, v);
        chk(v, 64'h1234_5678);
        wrn(16'h0936, 1, 64'hff);
        rdn(16'h0936, 1, v);
        chk(v, 64'h01);
        rdn(16'h0910, 8, v);
        chk(v, 64'h0);
        measure(32'h281e_1400, 8'h00, 0);
        // master side arithmetic on the captured stamps of one slave only
        chk((s[1] - s[0]) >> 1, 64'h1f4);
        chk(((s[3] - s[0]) - (s[2] - s[1]) + proc_fwd_delay_difference) >> 1, 64'h2f8);
        chk(((s[3] - s[0]) - (s[2] - s[1]) - proc_fwd_delay_difference) >> 1, 64'h2e4);
        t = s[1];
        wrn(16'h0904, 1, 64'hff);
        rdn(16'h0904, 4, v);
        chk(v, t);
        measure(32'h3228_001e, 8'h01, 1);
        wrn(16'h0928, 4, 64'h100);
        t = 64'(cyc + 1) * 64'h32;
        @(posedge core_clk);
        pu <= 1'b1;
        st <= 32'h20;
        st_v <= 1'b1;
        @(posedge core_clk);
        pu <= 1'b0;
        st_v <= 1'b0;
        #1;
        chk(64'(diff), (t - 64'h120) & 64'hffff_ffff);
        chk(64'(diff_v), 64'h1);
        chk(lt, t + 64'h32);
        // the processing unit stamp is taken over by the next measurement write
        wrn(16'h0900, 1, 64'h0);
        rdn(16'h0918, 8, v);
        chk(v, t);
        end_of_test();
    end
endmodule
`default_nettype wire

// ===== rtdm_top.sv
`default_nettype none
module rtdm_top #(
    // set for variants that arm on the write and stamp the following frame
    parameter bit ARM_NEXT_FRAME = 1'b0
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire rtdm_pkg::rtdm_acc_s acc,
    output rtdm_pkg::rtdm_rsp_s rsp,
    input wire logic [rtdm_pkg::NPORTS-1:0] port_rx_pin,
    input wire logic [rtdm_pkg::NPORTS-1:0] port_open,
    input wire logic pu_frame_start,
    input wire logic [31:0] sys_time_rx,
    input wire logic sys_time_rx_valid,
    output logic [63:0] local_time,
    output logic [31:0] sys_time_diff,
    output logic sys_time_diff_valid
);
    typedef struct packed {
        logic [63:0] local_time;
        logic [rtdm_pkg::NPORTS-1:0][31:0] shadow;
        logic [rtdm_pkg::NPORTS-1:0][31:0] stamp;
        logic [63:0] pu_shadow;
        logic [63:0] pu_stamp;
        logic [rtdm_pkg::NPORTS-1:0] armed;
        logic [31:0] delay;
        logic [7:0] latch_mode;
        rtdm_pkg::rtdm_rsp_s rsp;
        logic [31:0] diff;
        logic diff_valid;
    } rtdm_state_s;

    rtdm_state_s st_r;
    rtdm_state_s st_nxt;
    logic [rtdm_pkg::NPORTS-1:0] port_active;
    logic [rtdm_pkg::NPORTS-1:0] port_rise;
    logic meas_write;
    logic [31:0] word_sel;

    // preamble carrier from the phys is asynchronous, so it is resynchronised
    rtdm_pin_sync u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in(port_rx_pin),
        .level(port_active),
        .rise(port_rise)
    );

    // any write that covers the first byte of the port-0 stamp starts a measurement
    assign meas_write = acc.valid & acc.write & (acc.addr == rtdm_pkg::ADDR_STAMP0);

    // word behind a read address; the processing unit stamp spans two words
    always_comb begin
        word_sel = 32'h0000_0000;
        case ({acc.addr[15:2], 2'b00})
            rtdm_pkg::ADDR_STAMP0: word_sel = st_r.stamp[0];
            rtdm_pkg::ADDR_STAMP1: word_sel = st_r.stamp[1];
            rtdm_pkg::ADDR_STAMP2: word_sel = st_r.stamp[2];
            rtdm_pkg::ADDR_STAMP3: word_sel = st_r.stamp[3];
            rtdm_pkg::ADDR_PU_STAMP: word_sel = st_r.pu_stamp[31:0];
            rtdm_pkg::ADDR_PU_STAMP + 16'h0004: word_sel = st_r.pu_stamp[63:32];
            rtdm_pkg::ADDR_DELAY: word_sel = st_r.delay;
            {rtdm_pkg::ADDR_LATCH[15:2], 2'b00}: word_sel = {8'h00, st_r.latch_mode, 16'h0000};
            default: word_sel = 32'h0000_0000;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp.valid = 1'b0;
        st_nxt.diff_valid = 1'b0;

        // free-running local time in ns, never corrected here
        st_nxt.local_time = st_r.local_time + rtdm_pkg::LOCAL_TICK_NS;

        // every preamble start is shadowed so the write can pick it up later in the frame
        for (int p = 0; p < rtdm_pkg::NPORTS; p++) begin
            if (port_rise[p]) begin
                st_nxt.shadow[p] = st_r.local_time[31:0];
                if (st_r.armed[p]) begin
                    st_nxt.stamp[p] = st_r.local_time[31:0];
                    st_nxt.armed[p] = 1'b0;
                end
            end
        end

        // frame arrival at the processing unit, full 64 bits
        if (pu_frame_start) begin
            st_nxt.pu_shadow = st_r.local_time;
        end

        // measurement: entry port takes the stamp of this frame, the rest wait
        // for the frame coming back around the ring
        if (meas_write) begin
            st_nxt.pu_stamp = pu_frame_start ? st_r.local_time : st_r.pu_shadow;
            for (int p = 0; p < rtdm_pkg::NPORTS; p++) begin
                if (ARM_NEXT_FRAME) begin
                    // arming variant: port 0 from this frame, others from the next one if port 0 is open
                    if (p == 0) begin
                        st_nxt.stamp[p] = st_r.shadow[p];
                        st_nxt.armed[p] = 1'b0;
                    end else begin
                        st_nxt.armed[p] = port_open[0];
                    end
                end else if (st_r.latch_mode[0] ? port_active[p] : (p == 0)) begin
                    // entry port: port 0 in forward orientation, whichever one is receiving in reverse
                    st_nxt.stamp[p] = st_r.shadow[p];
                    st_nxt.armed[p] = 1'b0;
                end else begin
                    st_nxt.armed[p] = 1'b1;
                end
            end
        end

        // byte writes: delay register and latch orientation; stamps are read only
        if (acc.valid && acc.write) begin
            for (int b = 0; b < 4; b++) begin
                if (acc.addr == rtdm_pkg::ADDR_DELAY + 16'(b)) begin
                    st_nxt.delay[b*8 +: 8] = acc.wdata;
                end
            end
            if (acc.addr == rtdm_pkg::ADDR_LATCH) begin
                st_nxt.latch_mode = {7'h00, acc.wdata[0]};
            end
        end

        // read answer one cycle after the request; unmapped bytes read zero
        if (acc.valid && !acc.write) begin
            st_nxt.rsp.valid = 1'b1;
            st_nxt.rsp.data = word_sel[acc.addr[1:0]*8 +: 8];
        end

        // received system time compared with local copy minus path delay;
        // offset compensation lives elsewhere, so only local time is used
        if (sys_time_rx_valid) begin
            st_nxt.diff = st_r.local_time[31:0] - st_r.delay - sys_time_rx;
            st_nxt.diff_valid = 1'b1;
        end
    end

    // stamps keep their value across frames until the next measurement write
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.local_time <= rtdm_pkg::TIME_RESET;
            st_r.delay <= rtdm_pkg::DELAY_RESET;
            st_r.latch_mode <= rtdm_pkg::LATCH_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // four ports, so stamping is always built in
    assign rsp = st_r.rsp;
    assign local_time = st_r.local_time;
    assign sys_time_diff = st_r.diff;
    assign sys_time_diff_valid = st_r.diff_valid;
endmodule
`default_nettype wire
